// *** fpet_core.sv ***
// Flash program/erase sequencer with port pin hold logic
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
module fpet_core (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic flash_program,
   output logic flash_erase,
   output logic flash_mass,
   output logic flash_data_sel,
   output logic nonvolatile_store_strobe,
   output logic busy,
   input wire logic nmi_pin,
   output logic nmi_event,
   output logic [fpet_pkg::PORT_W-1:0] port_out,
   output logic [fpet_pkg::PORT_W-1:0] port_oe
);
   // Timing sets: [set][index]
   logic [fpet_pkg::CNT_W-1:0] tset_q [2][fpet_pkg::NIDX];
   logic [3:0] sel_idx_q;
   logic [1:0] op_q;
   logic mem_q;
   fpet_pkg::fpet_state_t st_q;
   logic [fpet_pkg::PORT_W-1:0] pout_q, pdir_q, pout_hold_q, pdir_hold_q;
   logic psave_q;
   logic nmi_s1_q, nmi_s2_q, nmi_s3_q;
   logic start_q, done;
   logic [31:0] periods;
   logic [fpet_pkg::PRE_W-1:0] pre;
   logic [31:0] rdata_q;

   function automatic logic [31:0] val(input logic s, input logic [3:0] i);
      val = {16'h0, tset_q[s][i]};
   endfunction : val

   assign pre = tset_q[mem_q][fpet_pkg::IDX_PRESCALE][fpet_pkg::PRE_W-1:0];

   // Interval lengths per phase, prescaler applied in the ticker
   always_comb begin
      periods = 32'h0;
      case (st_q)
         fpet_pkg::ST_SETUP: periods = val(mem_q, 4'(fpet_pkg::IDX_SETUP));
         fpet_pkg::ST_TRAN: periods = val(mem_q, 4'(fpet_pkg::IDX_TRAN));
         fpet_pkg::ST_PULSE: begin
            if (op_q == fpet_pkg::OP_PROG) begin
               periods = ((val(mem_q, 4'(fpet_pkg::IDX_PROG)) + 32'h1)
                  << fpet_pkg::MULT_PROG) - 32'h1;
            end else if (op_q == fpet_pkg::OP_PERASE) begin
               periods = ((val(mem_q, 4'(fpet_pkg::IDX_PER)) + 32'h1)
                  << fpet_pkg::MULT_ERASE) - 32'h1;
            end else begin
               periods = ((val(mem_q, 4'(fpet_pkg::IDX_MER)) + 32'h1)
                  << fpet_pkg::MULT_ERASE) - 32'h1;
            end
         end
         fpet_pkg::ST_HOLD: begin
            if (op_q == fpet_pkg::OP_MERASE) begin
               periods = ((val(mem_q, 4'(fpet_pkg::IDX_MEND)) + 32'h1)
                  << fpet_pkg::MULT_MEND) - 32'h1;
            end else begin
               periods = val(mem_q, 4'(fpet_pkg::IDX_END));
            end
         end
         fpet_pkg::ST_RCV: periods = val(mem_q, fpet_pkg::IDX_RCV);
         default: periods = 32'h0;
      endcase
   end

   fpet_ticker u_tick (
      .clk(clk),
      .nrst(nrst),
      .start(start_q),
      .prescale(pre),
      .periods(periods),
      .done(done)
   );

   // Sequencer; start_q kicks the ticker in the first cycle of each timed phase
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= fpet_pkg::ST_IDLE;
         op_q <= 2'd0;
         mem_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         start_q <= 1'b0;
         case (st_q)
            fpet_pkg::ST_IDLE: begin
               if (wr && addr == fpet_pkg::ADDR_CMD && wdata[1:0] != 2'd0) begin
                  op_q <= wdata[1:0];
                  mem_q <= wdata[4];
                  st_q <= fpet_pkg::ST_SETUP;
                  start_q <= 1'b1;
               end
            end
            fpet_pkg::ST_SETUP: if (done) begin
               st_q <= fpet_pkg::ST_TRAN;
               start_q <= 1'b1;
            end
            fpet_pkg::ST_TRAN: if (done) begin
               st_q <= fpet_pkg::ST_PULSE;
               start_q <= 1'b1;
            end
            fpet_pkg::ST_PULSE: if (done) begin
               st_q <= fpet_pkg::ST_HOLD;
               start_q <= 1'b1;
            end
            fpet_pkg::ST_HOLD: if (done) begin
               st_q <= fpet_pkg::ST_RCV;
               start_q <= 1'b1;
            end
            fpet_pkg::ST_RCV: if (done) begin
               st_q <= fpet_pkg::ST_IDLE;
            end
            default: st_q <= fpet_pkg::ST_IDLE;
         endcase
      end
   end

   // Flash control outputs, registered from state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flash_program <= 1'b0;
         flash_erase <= 1'b0;
         flash_mass <= 1'b0;
         nonvolatile_store_strobe <= 1'b0;
         flash_data_sel <= 1'b0;
      end else begin
         flash_data_sel <= mem_q;
         // Mode line stays up from setup through pulse
         flash_program <= (op_q == fpet_pkg::OP_PROG) &&
            (st_q inside {fpet_pkg::ST_SETUP, fpet_pkg::ST_TRAN,
            fpet_pkg::ST_PULSE});
         flash_erase <= (op_q != fpet_pkg::OP_PROG) &&
            (st_q inside {fpet_pkg::ST_SETUP, fpet_pkg::ST_TRAN,
            fpet_pkg::ST_PULSE});
         flash_mass <= (op_q == fpet_pkg::OP_MERASE) &&
            (st_q != fpet_pkg::ST_IDLE);
         nonvolatile_store_strobe <= st_q inside {fpet_pkg::ST_TRAN,
            fpet_pkg::ST_PULSE, fpet_pkg::ST_HOLD};
      end
   end
   assign busy = (st_q != fpet_pkg::ST_IDLE);

   // Timing set registers; locked while an operation runs
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sel_idx_q <= 4'h0;
         for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < fpet_pkg::NIDX; i++) begin
               tset_q[s][i] <= '0;
            end
         end
      end else if (wr) begin
         if (addr == fpet_pkg::ADDR_SEL_IDX) begin
            sel_idx_q <= wdata[3:0];
         end else if (!busy && sel_idx_q < 4'(fpet_pkg::NIDX) &&
            (addr == fpet_pkg::ADDR_SET_PROG ||
            addr == fpet_pkg::ADDR_SET_DATA)) begin
            tset_q[addr == fpet_pkg::ADDR_SET_DATA][sel_idx_q] <=
               wdata[fpet_pkg::CNT_W-1:0];
         end
      end
   end

   // Port pins and power-save
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pout_q <= '0;
         pdir_q <= '0;
         psave_q <= 1'b0;
         pout_hold_q <= '0;
         pdir_hold_q <= '0;
      end else begin
         if (wr && addr == fpet_pkg::ADDR_PORT_OUT) begin
            pout_q <= {wdata[21:0], wdata};
         end
         if (wr && addr == fpet_pkg::ADDR_PORT_DIR) begin
            pdir_q <= {wdata[21:0], wdata};
         end
         if (wr && addr == fpet_pkg::ADDR_PSAVE) begin
            psave_q <= wdata[0];
            if (wdata[0] && !psave_q) begin
               pout_hold_q <= pout_q;
               pdir_hold_q <= pdir_q;
            end
         end
      end
   end
   // Reset clears direction, so every pin floats while nrst is low
   assign port_out = psave_q ? pout_hold_q : pout_q;
   assign port_oe = psave_q ? pdir_hold_q : pdir_q;

   // NMI sampled regardless of power-save
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         nmi_s1_q <= 1'b0;
         nmi_s2_q <= 1'b0;
         nmi_s3_q <= 1'b0;
      end else begin
         nmi_s1_q <= nmi_pin;
         nmi_s2_q <= nmi_s1_q;
         nmi_s3_q <= nmi_s2_q;
      end
   end
   assign nmi_event = nmi_s2_q && !nmi_s3_q;

   // Register read, data in the following cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 32'h0;
      end else if (rd) begin
         case (addr)
            fpet_pkg::ADDR_STATUS: rdata_q <= {25'h0, 3'(st_q),
               op_q, mem_q, busy};
            fpet_pkg::ADDR_PSAVE: rdata_q <= {31'h0, psave_q};
            fpet_pkg::ADDR_SEL_IDX: rdata_q <= {28'h0, sel_idx_q};
            fpet_pkg::ADDR_SET_PROG: rdata_q <= (sel_idx_q <
               4'(fpet_pkg::NIDX)) ? val(1'b0, sel_idx_q) : 32'h0;
            fpet_pkg::ADDR_SET_DATA: rdata_q <= (sel_idx_q <
               4'(fpet_pkg::NIDX)) ? val(1'b1, sel_idx_q) : 32'h0;
            default: rdata_q <= 32'h0;
         endcase
      end
   end
   assign rdata = rdata_q;

   // Phase order seen at the flash control lines
   AST_STROBE_ONLY_WHEN_BUSY: assert property (
      @(posedge clk) disable iff (!nrst)
      nonvolatile_store_strobe |-> $past(busy))
      else $error("Strobe outside operation");
   AST_NO_PROG_AND_ERASE: assert property (
      @(posedge clk) disable iff (!nrst)
      !(flash_program && flash_erase))
      else $error("Program and erase together");
   AST_STROBE_AFTER_MODE: assert property (
      @(posedge clk) disable iff (!nrst)
      $rose(nonvolatile_store_strobe) |-> $past(flash_program || flash_erase))
      else $error("Strobe rose without mode");
   AST_MODE_BEFORE_STROBE: assert property (
      @(posedge clk) disable iff (!nrst)
      $rose(flash_program || flash_erase) |-> !nonvolatile_store_strobe)
      else $error("Strobe already up when mode rose");
   AST_MODE_DROPS_STROBE_HOLDS: assert property (
      @(posedge clk) disable iff (!nrst)
      $fell(flash_program || flash_erase) |-> nonvolatile_store_strobe)
      else $error("Strobe not held after pulse");
   AST_RCV_AFTER_STROBE: assert property (
      @(posedge clk) disable iff (!nrst)
      $fell(nonvolatile_store_strobe) |-> busy)
      else $error("No recovery after strobe");
   AST_MASS_IS_ERASE: assert property (
      @(posedge clk) disable iff (!nrst)
      $rose(flash_mass) |-> flash_erase && !flash_program)
      else $error("Mass line without erase");
   AST_IDLE_QUIET: assert property (
      @(posedge clk) disable iff (!nrst)
      !busy && !$past(busy) |-> !(nonvolatile_store_strobe || flash_program ||
      flash_erase || flash_mass))
      else $error("Flash lines active while idle");
   // Settings and command frozen for the whole operation; pins held in power-save, NMI edge passed through
   AST_SET_STABLE: assert property (
      @(posedge clk) disable iff (!nrst)
      busy && $past(busy) |-> $stable(mem_q))
      else $error("Timing set changed mid operation");
   AST_PRESCALE_LOCKED: assert property (
      @(posedge clk) disable iff (!nrst)
      busy && $past(busy) |-> $stable(pre))
      else $error("Prescale changed mid operation");
   AST_OP_LOCKED: assert property (
      @(posedge clk) disable iff (!nrst)
      busy && $past(busy) |-> $stable(op_q))
      else $error("Command accepted mid operation");
   AST_HOLD_PINS: assert property (
      @(posedge clk) disable iff (!nrst)
      psave_q && $past(psave_q) |-> $stable(port_out) && $stable(port_oe))
      else $error("Pins changed in power-save");
   AST_NMI_LIVE: assert property (
      @(posedge clk) disable iff (!nrst)
      $rose(nmi_s2_q) |-> nmi_event ##1 !nmi_event)
      else $error("NMI missed or stretched");

   COV_PROG: cover property (@(posedge clk) $rose(flash_program));
   COV_PAGE_ERASE: cover property (@(posedge clk)
      $rose(flash_erase) && !flash_mass);
   COV_MASS: cover property (@(posedge clk) $rose(flash_mass));
   COV_DATA_FLASH: cover property (@(posedge clk) $rose(flash_data_sel));
   COV_PSAVE: cover property (@(posedge clk) $rose(psave_q));
endmodule : fpet_core

// *** fpet_pkg.sv ***
// Package: constants and types for the flash program/erase timing block
package fpet_pkg;
   localparam int unsigned CLK_HZ = 50000000;
   localparam logic [3:0] ADDR_CMD = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_PORT_OUT = 4'h2;
   localparam logic [3:0] ADDR_PORT_DIR = 4'h3;
   localparam logic [3:0] ADDR_PSAVE = 4'h4;
   // Per-memory timing set: base 4'h8 program flash, 4'h9 data flash
   localparam logic [3:0] ADDR_SET_PROG = 4'h8;
   localparam logic [3:0] ADDR_SET_DATA = 4'h9;
   localparam logic [3:0] ADDR_SEL_IDX = 4'ha;
   localparam logic [3:0] ADDR_SEL_VAL = 4'hb;
   localparam int PRE_W = 8;
   localparam int CNT_W = 16;
   localparam int PORT_W = 54;
   localparam logic [2:0] MULT_PROG = 3'd3;
   localparam logic [3:0] MULT_ERASE = 4'd12;
   localparam logic [2:0] MULT_MEND = 3'd3;
   localparam logic [1:0] OP_PROG = 2'd1;
   localparam logic [1:0] OP_PERASE = 2'd2;
   localparam logic [1:0] OP_MERASE = 2'd3;
   typedef enum logic [2:0] {
      IDX_PRESCALE, IDX_SETUP, IDX_TRAN, IDX_PROG,
      IDX_PER, IDX_MER, IDX_END, IDX_MEND
   } fpet_idx_t;
   localparam logic [3:0] IDX_RCV = 4'd8;
   localparam int NIDX = 9;
   typedef enum {
      ST_IDLE, ST_SETUP, ST_TRAN, ST_PULSE, ST_HOLD, ST_RCV
   } fpet_state_t;
endpackage : fpet_pkg

// *** fpet_ticker.sv ***
// Prescaler and interval counter for one timed phase
`timescale 1ns/1ps
module fpet_ticker (
   input wire logic clk,
   input wire logic nrst,
   input wire logic start,
   input wire logic [fpet_pkg::PRE_W-1:0] prescale,
   input wire logic [31:0] periods,
   output logic done
);
   logic [fpet_pkg::PRE_W-1:0] pre_q;
   logic [31:0] cnt_q;
   logic run_q;
   logic tick;
   // Tick once every prescale+1 clocks
   assign tick = run_q && (pre_q == prescale);
   assign done = tick && (cnt_q == 32'h0);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pre_q <= '0;
         cnt_q <= 32'h0;
         run_q <= 1'b0;
      end else if (start) begin
         pre_q <= '0;
         cnt_q <= periods;
         run_q <= 1'b1;
      end else if (run_q) begin
         pre_q <= tick ? '0 : pre_q + 1'b1;
         if (tick) begin
            if (cnt_q == 32'h0) begin
               run_q <= 1'b0;
            end else begin
               cnt_q <= cnt_q - 32'h1;
            end
         end
      end
   end
endmodule : fpet_ticker

// *** fpet_flash_model.sv ***
// Flash array model that times each phase seen at its control pins
`timescale 1ns/1ps
module fpet_flash_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic flash_program,
   input wire logic flash_erase,
   input wire logic flash_mass,
   input wire logic flash_data_sel,
   input wire logic nonvolatile_store_strobe,
   input wire logic busy,
   output logic done,
   output logic [2:0] op_mem,
   output logic [31:0] t_setup,
   output logic [31:0] t_pulse,
   output logic [31:0] t_hold,
   output logic [31:0] t_rcv,
   output logic bad_order
);
   logic mode, mode_q, stb_q, busy_q;
   logic [31:0] cnt_q;
   // Mass line stays up through recovery, so it cannot mark the pulse end
   assign mode = flash_program | flash_erase;
   // Edge-to-edge counts; a phase is measured between two pin edges
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         {mode_q, stb_q, busy_q, done, bad_order} <= '0;
         cnt_q <= '0;
         {op_mem, t_setup, t_pulse, t_hold, t_rcv} <= '0;
      end else begin
         mode_q <= mode;
         stb_q <= nonvolatile_store_strobe;
         busy_q <= busy;
         cnt_q <= cnt_q + 1;
         done <= 1'b0;
         if (mode && !mode_q) begin
            cnt_q <= 1;
            op_mem <= {flash_data_sel, flash_mass ? 2'd3 :
                       flash_program ? 2'd1 : 2'd2};
         end
         if (nonvolatile_store_strobe && !stb_q) begin
            t_setup <= cnt_q;
            cnt_q <= 1;
            if (!mode) bad_order <= 1'b1;
         end
         if (!mode && mode_q) begin
            t_pulse <= cnt_q;
            cnt_q <= 1;
            if (!nonvolatile_store_strobe) bad_order <= 1'b1;
         end
         if (!nonvolatile_store_strobe && stb_q) begin
            t_hold <= cnt_q;
            cnt_q <= 1;
         end
         if (!busy && busy_q) begin
            t_rcv <= cnt_q;
            done <= 1'b1;
         end
      end
   end
endmodule : fpet_flash_model

// *** test_flash_program_erase_timing.sv ***
// Self-checking testbench for the flash program/erase timing block
`timescale 1ns/1ps
module test_flash_program_erase_timing;
   logic clk, nrst, wr, rd, nmi_pin, nmi_event, done, bad_order, seen;
   logic fp, fe, fm, fds, stb, busy;
   logic [3:0] addr;
   logic [2:0] op_mem;
   logic [31:0] wdata, rdata, lfsr, pv, d, t_su, t_pl, t_hd, t_rc;
   logic [31:0] sp [9];
   logic [31:0] sd [9];
   logic [fpet_pkg::PORT_W-1:0] port_out, port_oe;
   logic [31:0] expq [$];
   int num_errors, cmp_count, cyc;
   fpet_core u_fpet_core (.clk(clk), .nrst(nrst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .flash_program(fp), .flash_erase(fe), .flash_mass(fm),
      .flash_data_sel(fds), .nonvolatile_store_strobe(stb), .busy(busy),
      .nmi_pin(nmi_pin), .nmi_event(nmi_event), .port_out(port_out),
      .port_oe(port_oe));
   fpet_flash_model u_fpet_flash_model (.clk(clk), .nrst(nrst),
      .flash_program(fp), .flash_erase(fe), .flash_mass(fm),
      .flash_data_sel(fds), .nonvolatile_store_strobe(stb), .busy(busy),
      .done(done), .op_mem(op_mem), .t_setup(t_su), .t_pulse(t_pl),
      .t_hold(t_hd), .t_rcv(t_rc), .bad_order(bad_order));
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_val
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict
   // Gap cycle after each strobe keeps one assignment per time step
   task automatic wreg(input logic [3:0] a, input logic [31:0] v);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wreg
   task automatic rreg(input logic [3:0] a, output logic [31:0] v);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      // Data stand in the cycle after the strobe; taken at its end
      @(posedge clk);
      v = rdata;
   endtask : rreg
   task automatic load(input logic [3:0] a, input logic [31:0] s [9]);
      for (int i = 0; i < 9; i++) begin
         wreg(fpet_pkg::ADDR_SEL_IDX, 32'(i));
         wreg(a, s[i]);
      end
   endtask : load
   task automatic start_op(input logic [1:0] op, input logic mem);
      logic [31:0] s [9];
      logic [31:0] p, m;
      for (int i = 0; i < 9; i++) begin
         s[i] = mem ? sd[i] : sp[i];
      end
      p = s[0] + 1;
      m = (op == fpet_pkg::OP_PROG) ? 32'd8 : 32'd4096;
      expq.push_back({29'h0, mem, op});
      expq.push_back(p * (s[1] + 1) + 1);
      expq.push_back(p * (s[2] + 1) + 1 + p * m * (s[int'(op) + 2] + 1) + 1);
      expq.push_back(op == fpet_pkg::OP_MERASE ? p * 8 * (s[7] + 1) + 1
                     : p * (s[6] + 1) + 1);
      expq.push_back(p * (s[8] + 1));
      wreg(fpet_pkg::ADDR_CMD, {27'h0, mem, 2'b00, op});
   endtask : start_op
   // A hung sequencer counts as a mismatch
   task automatic wait_idle;
      for (int k = 0; k < 20000 && busy !== 1'b0; k++) begin
         @(posedge clk);
      end
      if (busy !== 1'b0) begin
         num_errors++;
         $display("Error at %0t: operation did not end", $time);
      end
      repeat (3) @(posedge clk);
   endtask : wait_idle
   task automatic run_op(input logic [1:0] op, input logic mem);
      start_op(op, mem);
      wait_idle();
   endtask : run_op
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         num_errors++;
         give_verdict();
      end
   end
   // Watcher: each completed operation takes the oldest five notes
   always @(posedge clk) begin
      if (done === 1'b1) begin
         if (expq.size() < 5) begin
            num_errors++;
            $display("Error at %0t: unexpected operation", $time);
         end else begin
            check_val({29'h0, op_mem}, expq.pop_front());
            check_val(t_su, expq.pop_front());
            check_val(t_pl, expq.pop_front());
            check_val(t_hd, expq.pop_front());
            check_val(t_rc, expq.pop_front());
         end
         check_val({31'h0, bad_order}, 32'h0);
      end
   end
   initial begin
      {nrst, wr, rd, nmi_pin, addr, wdata} = '0;
      lfsr = 32'hf757;
      repeat (3) @(posedge clk);
      check_val(port_oe[31:0], 32'h0);
      check_val({10'h0, port_oe[53:32]}, 32'h0);
      nrst <= 1'b1;
      @(posedge clk);
      // Small random counts; erase counts 0 keep the run short
      for (int i = 0; i < 9; i++) begin
         lfsr = lfsr_next(lfsr);
         sp[i] = {30'h0, lfsr[1:0]};
         sd[i] = {30'h0, lfsr[3:2]};
      end
      {sp[0][1], sd[0][1], sp[4], sp[5], sd[4], sd[5]} = '0;
      load(fpet_pkg::ADDR_SET_PROG, sp);
      load(fpet_pkg::ADDR_SET_DATA, sd);
      // Few short program pulses keep row exposure far below limit
      run_op(fpet_pkg::OP_PROG, 1'b0);
      run_op(fpet_pkg::OP_PROG, 1'b1);
      start_op(fpet_pkg::OP_PERASE, 1'b0);
      rreg(fpet_pkg::ADDR_STATUS, d);
      check_val({31'h0, d[0]}, 32'h1);
      check_val({29'h0, d[3:1]}, {29'h0, fpet_pkg::OP_PERASE, 1'b0});
      wreg(fpet_pkg::ADDR_CMD, {27'h0, 1'b1, 2'b00, fpet_pkg::OP_PROG});
      wreg(fpet_pkg::ADDR_SEL_IDX, 32'h8);
      wreg(fpet_pkg::ADDR_SET_PROG, sp[8] + 5);
      // Op code 0 is refused too, so no note is queued for it
      wreg(fpet_pkg::ADDR_CMD, {27'h0, 1'b1, 4'h0});
      wait_idle();
      run_op(fpet_pkg::OP_MERASE, 1'b1);
      run_op(fpet_pkg::OP_PROG, 1'b0);
      wreg(fpet_pkg::ADDR_CMD, 32'h0);
      rreg(fpet_pkg::ADDR_SET_PROG, d);
      check_val(d, sp[8]);
      lfsr = lfsr_next(lfsr);
      pv = lfsr;
      lfsr = lfsr_next(lfsr);
      wreg(fpet_pkg::ADDR_PORT_OUT, pv);
      wreg(fpet_pkg::ADDR_PORT_DIR, lfsr);
      wreg(fpet_pkg::ADDR_PSAVE, 32'h1);
      check_val(port_out[31:0], pv);
      check_val(port_oe[31:0], lfsr);
      check_val({10'h0, port_oe[53:32]}, {10'h0, lfsr[21:0]});
      wreg(fpet_pkg::ADDR_PORT_OUT, ~pv);
      check_val(port_out[31:0], pv);
      check_val({10'h0, port_out[53:32]}, {10'h0, pv[21:0]});
      nmi_pin <= 1'b1;
      seen = 1'b0;
      repeat (6) begin
         @(posedge clk);
         if (nmi_event === 1'b1) seen = 1'b1;
      end
      check_val({31'h0, seen}, 32'h1);
      nmi_pin <= 1'b0;
      nrst <= 1'b0;
      @(posedge clk);
      check_val(port_oe[31:0], 32'h0);
      check_val({10'h0, port_oe[53:32]}, 32'h0);
      nrst <= 1'b1;
      @(posedge clk);
      foreach (sp[i]) sp[i] = '0;
      run_op(fpet_pkg::OP_PROG, 1'b0);
      check_val(32'(expq.size()), 32'h0);
      give_verdict();
   end
endmodule : test_flash_program_erase_timing
